// *** design/bog_pkg.sv ***
package bog_pkg;
	// Register offsets
	localparam logic [7:0] OFS_CONTROL = 8'h14;
	localparam logic [7:0] OFS_ATTACK_HOLD = 8'h15;
	localparam logic [7:0] OFS_CURLIM_HOLD = 8'h16;
	localparam logic [7:0] OFS_ALIGN_A = 8'h17;
	localparam logic [7:0] OFS_ALIGN_B = 8'h18;
	localparam logic [7:0] OFS_ALIGN_C = 8'h19;
	localparam logic [7:0] OFS_INTERRUPT_MASK_GROUP0 = 8'h1A;
	localparam logic [7:0] OFS_EVT_STATUS = 8'h20;
	localparam logic [7:0] OFS_EVT_MASK = 8'h21;
	localparam logic [7:0] OFS_GUARD_STATE = 8'h22;
	// Reset values
	localparam logic [7:0] RST_CONTROL = 8'h01;
	localparam logic [7:0] RST_ATTACK_HOLD = 8'h2E;
	localparam logic [7:0] RST_CURLIM_HOLD = 8'h60;
	localparam logic [7:0] RST_INTERRUPT_MASK_GROUP0 = 8'hFC;
	localparam logic [7:0] RST_EVT_MASK = 8'h0F;
	// Write masks of mixed registers
	localparam logic [7:0] WMASK_CONTROL = 8'h1F;
	localparam logic [7:0] WMASK_CURLIM = 8'h70;
	// Control field positions
	localparam int BIT_AUX_EN = 4;
	localparam int BIT_HOLD_RELEASE = 3;
	localparam int BIT_HOLD_FOREVER = 2;
	localparam int BIT_MUTE_SHUT = 1;
	localparam int BIT_GUARD_EN = 0;
	// Attack/hold field positions
	localparam int POS_ATK_RATE = 5;
	localparam int POS_ATK_STEP = 3;
	localparam int POS_HOLD_TM = 0;
	localparam int POS_CURLIM_TM = 4;
	// Status event bits
	localparam int EVT_ATTACK = 0;
	localparam int EVT_HOLD_DONE = 1;
	localparam int EVT_RELEASED = 2;
	localparam int EVT_SHUTDOWN = 3;
	// Timing
	localparam int CLK_MHZ = 100;
	localparam int MS_CYCLES = 1000 * CLK_MHZ;
	localparam int RLS_BASE_MS = 10;
	// Attenuation in quarter dB, 8 bits saturates at 63.75 dB
	localparam logic [7:0] ATTEN_MAX = 8'hFF;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ATTACK = 2'b01,
		ST_HOLD = 2'b10,
		ST_RELEASE = 2'b11
	} bog_state_t;

	// Hold code to milliseconds
	function automatic logic [9:0] hold_ms(input logic [2:0] code);
		case (code)
			3'h0: hold_ms = 10'd0;
			3'h1: hold_ms = 10'd10;
			3'h2: hold_ms = 10'd25;
			3'h3: hold_ms = 10'd50;
			3'h4: hold_ms = 10'd100;
			3'h5: hold_ms = 10'd250;
			3'h6: hold_ms = 10'd500;
			default: hold_ms = 10'd1000;
		endcase
	endfunction
endpackage

// *** design/bog_interval_timer.sv ***
// Counts a programmed number of ticks, pulsing done at the end
module bog_interval_timer import bog_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Control
	input wire logic start,
	input wire logic tick,
	input wire logic [31:0] length,
	// Status
	output logic busy,
	output logic done
);
	logic [31:0] count_r;

	// Load on start, count down on tick
	always_ff @(posedge clock) begin
		if (reset) begin
			count_r <= 32'h0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				count_r <= length;
				busy <= (length != 32'h0);
				done <= (length == 32'h0);
			end else if (busy && tick) begin
				if (count_r <= 32'h1) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
				count_r <= count_r - 32'h1;
			end
		end
	end
endmodule

// *** design/bog_ms_tick.sv ***
// One-cycle pulse every millisecond
module bog_ms_tick import bog_pkg::*; #(
	parameter int MS_LEN = MS_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Tick out
	output logic tick
);
	logic [31:0] cnt_r;

	// Free running divider
	always_ff @(posedge clock) begin
		if (reset) begin
			cnt_r <= 32'h0;
			tick <= 1'b0;
		end else begin
			tick <= (cnt_r == 32'(MS_LEN - 1));
			cnt_r <= (cnt_r == 32'(MS_LEN - 1)) ? 32'h0 : cnt_r + 32'h1;
		end
	end
endmodule

// *** design/brownout_guard_config.sv ***
// The Wishbone interface to the registers was decided locally.
module brownout_guard_config import bog_pkg::*; #(
	parameter int MS_LEN = MS_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	// Brown-out event and sample strobe
	input wire logic brownoutPin,
	input wire logic sampleStrobe,
	// Shared limiter release settings
	input wire logic [1:0] limiterReleaseStep,
	input wire logic [2:0] limiterReleaseRate,
	// Gain and power control
	output logic [7:0] attenuationQdb,
	output logic muteOut,
	output logic shutdownOut,
	output logic auxEnableOut,
	output logic [2:0] currentLimiterHoldTime,
	output logic [7:0] interruptMaskGroup0,
	// Interrupt
	output logic irq
);
	logic [7:0] control_r;
	logic [7:0] attackHold_r;
	logic [7:0] curlimHold_r;
	logic [7:0] alignA_r;
	logic [7:0] alignC_r;
	logic [7:0] intMask0_r;
	logic [3:0] evtStatus_r;
	logic [3:0] evtMask_r;
	logic [3:0] evtSet;
	logic bo1_r;
	logic bo2_r;
	logic releaseReq_r;
	logic [7:0] sampleCnt_r;
	logic [7:0] atten_r;
	logic muted_r;
	logic shut_r;
	bog_state_t state_r;
	bog_state_t state_nxt;
	logic reqValid;
	logic wrStrobe;
	logic rdHit;
	logic [7:0] rdData;
	logic msTick;
	logic holdStart;
	logic holdBusy;
	logic holdDone;
	logic rlsStart;
	logic rlsBusy;
	logic rlsDone;
	logic [31:0] holdLen;
	logic [31:0] rlsLen;
	logic guardOn;
	logic [2:0] atkRate;
	logic [1:0] atkStep;
	logic [7:0] atkQdb;
	logic [7:0] rlsQdb;
	logic atkDue;
	logic [8:0] attenSum;

	// Address is in the map
	function automatic logic addr_mapped(input logic [7:0] adr);
		addr_mapped = (adr >= OFS_CONTROL && adr <= OFS_INTERRUPT_MASK_GROUP0) ||
			(adr >= OFS_EVT_STATUS && adr <= OFS_GUARD_STATE);
	endfunction

	// Bus request decode
	assign reqValid = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign rdHit = addr_mapped(wb_adr_i);
	assign wrStrobe = reqValid && wb_we_i && wb_sel_i[0] && rdHit;

	// One-cycle answer, error on unmapped address
	always_ff @(posedge clock) begin
		if (reset) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= reqValid && rdHit;
			wb_err_o <= reqValid && !rdHit;
			wb_dat_o <= {24'h0, rdData};
		end
	end

	// Read mux
	always_comb begin
		case (wb_adr_i)
			OFS_CONTROL: rdData = control_r & 8'h17;
			OFS_ATTACK_HOLD: rdData = attackHold_r;
			OFS_CURLIM_HOLD: rdData = curlimHold_r & WMASK_CURLIM;
			OFS_ALIGN_A: rdData = alignA_r;
			OFS_ALIGN_B: rdData = 8'h00;
			OFS_ALIGN_C: rdData = alignC_r;
			OFS_INTERRUPT_MASK_GROUP0: rdData = intMask0_r;
			OFS_EVT_STATUS: rdData = {4'h0, evtStatus_r};
			OFS_EVT_MASK: rdData = {4'h0, evtMask_r};
			OFS_GUARD_STATE: rdData = {3'h0, shut_r, muted_r, bo2_r, state_r};
			default: rdData = 8'h00;
		endcase
	end

	// Control register with self-clearing release bit
	always_ff @(posedge clock) begin
		if (reset) begin
			control_r <= RST_CONTROL;
		end else if (wrStrobe && wb_adr_i == OFS_CONTROL) begin
			control_r <= wb_dat_i[7:0] & WMASK_CONTROL;
		end else begin
			control_r[BIT_HOLD_RELEASE] <= 1'b0;
		end
	end

	// Release request pulse from a written one
	always_ff @(posedge clock) begin
		if (reset) begin
			releaseReq_r <= 1'b0;
		end else begin
			releaseReq_r <= wrStrobe && wb_adr_i == OFS_CONTROL && wb_dat_i[BIT_HOLD_RELEASE];
		end
	end

	// Configuration registers
	always_ff @(posedge clock) begin
		if (reset) begin
			attackHold_r <= RST_ATTACK_HOLD;
			curlimHold_r <= RST_CURLIM_HOLD;
			alignA_r <= 8'h00;
			alignC_r <= 8'h00;
			intMask0_r <= RST_INTERRUPT_MASK_GROUP0;
		end else if (wrStrobe) begin
			case (wb_adr_i)
				OFS_ATTACK_HOLD: attackHold_r <= wb_dat_i[7:0];
				OFS_CURLIM_HOLD: curlimHold_r <= wb_dat_i[7:0] & WMASK_CURLIM;
				OFS_ALIGN_A: alignA_r <= wb_dat_i[7:0];
				OFS_ALIGN_C: alignC_r <= wb_dat_i[7:0];
				OFS_INTERRUPT_MASK_GROUP0: intMask0_r <= wb_dat_i[7:0];
				default: ;
			endcase
		end
	end

	// Brown-out input synchroniser
	always_ff @(posedge clock) begin
		if (reset) begin
			bo1_r <= 1'b0;
			bo2_r <= 1'b0;
		end else begin
			bo1_r <= brownoutPin;
			bo2_r <= bo1_r;
		end
	end

	assign guardOn = control_r[BIT_GUARD_EN] || control_r[BIT_AUX_EN];
	assign atkRate = attackHold_r[POS_ATK_RATE +: 3];
	assign atkStep = attackHold_r[POS_ATK_STEP +: 2];
	assign atkQdb = {5'h0, atkStep, 1'b0} + 8'h02;
	assign rlsQdb = 8'h01 << limiterReleaseStep;
	assign atkDue = sampleStrobe && (sampleCnt_r == 8'((9'h001 << atkRate) - 9'h001));
	assign holdLen = {22'h0, hold_ms(attackHold_r[POS_HOLD_TM +: 3])};
	assign rlsLen = 32'(RLS_BASE_MS) << limiterReleaseRate;

	// Sample counter for the attack rate
	always_ff @(posedge clock) begin
		if (reset) begin
			sampleCnt_r <= 8'h00;
		end else if (state_r != ST_ATTACK || atkDue) begin
			sampleCnt_r <= 8'h00;
		end else if (sampleStrobe) begin
			sampleCnt_r <= sampleCnt_r + 8'h01;
		end
	end

	bog_ms_tick #(.MS_LEN(MS_LEN)) u_tick (
		.clock(clock),
		.reset(reset),
		.tick(msTick)
	);

	bog_interval_timer u_hold (
		.clock(clock),
		.reset(reset),
		.start(holdStart),
		.tick(msTick),
		.length(holdLen),
		.busy(holdBusy),
		.done(holdDone)
	);

	bog_interval_timer u_release (
		.clock(clock),
		.reset(reset),
		.start(rlsStart),
		.tick(msTick),
		.length(rlsLen),
		.busy(rlsBusy),
		.done(rlsDone)
	);

	// Timed hold starts when the event clears
	assign holdStart = state_r == ST_ATTACK && !bo2_r && !control_r[BIT_HOLD_FOREVER];
	assign rlsStart = (state_r == ST_HOLD && state_nxt == ST_RELEASE) ||
		(state_r == ST_RELEASE && rlsDone && atten_r > rlsQdb);

	// Guard state machine
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: if (guardOn && bo2_r) state_nxt = ST_ATTACK;
			ST_ATTACK: if (!bo2_r) state_nxt = ST_HOLD;
			ST_HOLD: begin
				if (bo2_r) begin
					state_nxt = ST_ATTACK;
				end else if (control_r[BIT_HOLD_FOREVER]) begin
					if (releaseReq_r) state_nxt = ST_RELEASE;
				end else if (holdDone || (!holdBusy && !holdStart && releaseReq_r)) begin
					state_nxt = ST_RELEASE;
				end
			end
			ST_RELEASE: begin
				if (bo2_r) state_nxt = ST_ATTACK;
				else if (atten_r == 8'h00) state_nxt = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase
		if (!guardOn || shut_r) state_nxt = ST_IDLE;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign attenSum = {1'b0, atten_r} + {1'b0, atkQdb};

	// Attenuation: attack up, release down
	always_ff @(posedge clock) begin
		if (reset) begin
			atten_r <= 8'h00;
		end else if (!guardOn) begin
			atten_r <= 8'h00;
		end else if (state_r == ST_ATTACK && atkDue) begin
			atten_r <= attenSum[8] ? ATTEN_MAX : attenSum[7:0];
		end else if (state_r == ST_RELEASE && rlsDone) begin
			atten_r <= (atten_r > rlsQdb) ? atten_r - rlsQdb : 8'h00;
		end
	end

	// Mute then shutdown on brown-out
	always_ff @(posedge clock) begin
		if (reset) begin
			muted_r <= 1'b0;
			shut_r <= 1'b0;
		end else begin
			if (guardOn && bo2_r && control_r[BIT_MUTE_SHUT]) muted_r <= 1'b1;
			if (muted_r) shut_r <= 1'b1;
		end
	end

	// Event sources
	assign evtSet[EVT_ATTACK] = state_r != ST_ATTACK && state_nxt == ST_ATTACK;
	assign evtSet[EVT_HOLD_DONE] = state_r == ST_HOLD && state_nxt == ST_RELEASE;
	assign evtSet[EVT_RELEASED] = state_r == ST_RELEASE && state_nxt == ST_IDLE && !bo2_r;
	assign evtSet[EVT_SHUTDOWN] = muted_r && !shut_r;

	// Sticky status, set wins over write-one clear
	always_ff @(posedge clock) begin
		if (reset) begin
			evtStatus_r <= 4'h0;
		end else if (wrStrobe && wb_adr_i == OFS_EVT_STATUS) begin
			evtStatus_r <= (evtStatus_r & ~wb_dat_i[3:0]) | evtSet;
		end else begin
			evtStatus_r <= evtStatus_r | evtSet;
		end
	end

	// Event mask, one enables
	always_ff @(posedge clock) begin
		if (reset) begin
			evtMask_r <= RST_EVT_MASK[3:0];
		end else if (wrStrobe && wb_adr_i == OFS_EVT_MASK) begin
			evtMask_r <= wb_dat_i[3:0];
		end
	end

	// Outputs
	assign irq = |(evtStatus_r & evtMask_r);
	assign attenuationQdb = atten_r;
	assign muteOut = muted_r;
	assign shutdownOut = shut_r;
	assign auxEnableOut = control_r[BIT_AUX_EN];
	assign currentLimiterHoldTime = curlimHold_r[POS_CURLIM_TM +: 3];
	// Mask passed to the interrupt logic
	assign interruptMaskGroup0 = intMask0_r;
endmodule

// *** tb/bog_guard_monitor.sv ***
// Watches the register bus and guard outputs of the brown-out block
module bog_guard_monitor import bog_pkg::*; #(
	parameter int MS_LEN = MS_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	// Guard outputs
	input wire logic [7:0] attenuationQdb,
	input wire logic muteOut,
	input wire logic shutdownOut,
	input wire logic auxEnableOut,
	input wire logic [2:0] currentLimiterHoldTime,
	input wire logic [7:0] interruptMaskGroup0
);
	logic req;
	logic mapped;
	logic wr;

	// Request taken, address decode, accepted write
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign mapped = (wb_adr_i >= 8'h14 && wb_adr_i <= 8'h1A) || (wb_adr_i >= 8'h20 && wb_adr_i <= 8'h22);
	assign wr = req && mapped && wb_we_i && wb_sel_i[0];

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_ACK_MAPPED: assert property (req && mapped |=> wb_ack_o && !wb_err_o)
		else $error("mapped access not acknowledged");
	AST_ERR_UNMAPPED: assert property (req && !mapped |=> wb_err_o && !wb_ack_o)
		else $error("unmapped access not refused");
	AST_RD_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper read bits not zero");
	AST_RSVD_RO: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h18 |-> wb_dat_o == 32'h0)
		else $error("read-only reserved byte not zero");
	AST_CURLIM_WR: assert property (wr && wb_adr_i == 8'h16 |=> currentLimiterHoldTime == $past(wb_dat_i[6:4]))
		else $error("current limiter hold not stored");
	AST_MASK_WR: assert property (wr && wb_adr_i == 8'h1A |=> interruptMaskGroup0 == $past(wb_dat_i[7:0]))
		else $error("mask group not stored");
	AST_AUX_WR: assert property (wr && wb_adr_i == 8'h14 |=> auxEnableOut == $past(wb_dat_i[4]))
		else $error("aux enable not stored");
	AST_MUTE_SHUT: assert property ($rose(muteOut) |=> shutdownOut [*4])
		else $error("shutdown did not follow mute");
	AST_MUTE_HOLD: assert property (muteOut |=> muteOut)
		else $error("mute released before reset");
	AST_ATK_STEP: assert property (attenuationQdb > $past(attenuationQdb) |-> attenuationQdb - $past(attenuationQdb) <= 8'h08)
		else $error("attenuation rose by more than one step");

	// Main scenarios reached
	COV_ERR: cover property (req && !mapped);
	COV_MUTE: cover property ($rose(muteOut));
	COV_TWO_STEPS: cover property (attenuationQdb == 8'h10);
	COV_RELEASE_BIT: cover property (wr && wb_adr_i == 8'h14 && wb_dat_i[3]);
endmodule

bind brownout_guard_config bog_guard_monitor #(.MS_LEN(MS_LEN)) u_mon (.clock(clock),
	.reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .attenuationQdb(attenuationQdb),
	.muteOut(muteOut), .shutdownOut(shutdownOut), .auxEnableOut(auxEnableOut),
	.currentLimiterHoldTime(currentLimiterHoldTime), .interruptMaskGroup0(interruptMaskGroup0));

// *** tb/brownout_guard_config_bench.sv ***
// Self-checking bench for the brown-out register slice
module brownout_guard_config_bench import bog_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// Rows: write flag, offset, write data, expected readback
	localparam logic [24:0] ROWS [15] = '{
		{1'b0, 8'h14, 8'h00, 8'h01}, {1'b0, 8'h15, 8'h00, 8'h2E}, {1'b0, 8'h16, 8'h00, 8'h60},
		{1'b0, 8'h17, 8'h00, 8'h00}, {1'b0, 8'h18, 8'h00, 8'h00}, {1'b0, 8'h19, 8'h00, 8'h00},
		{1'b0, 8'h1A, 8'h00, 8'hFC}, {1'b1, 8'h16, 8'hFF, 8'h70}, {1'b1, 8'h18, 8'hFF, 8'h00},
		{1'b1, 8'h17, 8'hA5, 8'hA5}, {1'b1, 8'h19, 8'h5A, 8'h5A}, {1'b1, 8'h14, 8'hFF, 8'h17},
		{1'b1, 8'h15, 8'hFF, 8'hFF}, {1'b1, 8'h1A, 8'h03, 8'h03}, {1'b0, 8'h21, 8'h00, 8'h0F}};
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hF;
	logic [31:0] dat = 32'h0;
	logic pin = 1'b0;
	logic strobe = 1'b0;
	logic [1:0] sc = 2'h0;
	logic [1:0] rlsStep = 2'h3;
	logic [2:0] rlsRate = 3'h0;
	logic [31:0] rd;
	logic errSeen;
	logic [7:0] held;
	logic [31:0] datOut;
	logic ack, err, mute, shut, aux, irq;
	logic [7:0] atten, mask0;
	logic [2:0] curlim;
	int fail_count = 0;
	int num_checks = 0;

	brownout_guard_config #(.MS_LEN(10)) u_dut (.clock(clock), .reset(reset), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(datOut), .wb_ack_o(ack), .wb_err_o(err), .brownoutPin(pin),
		.sampleStrobe(strobe), .limiterReleaseStep(rlsStep), .limiterReleaseRate(rlsRate),
		.attenuationQdb(atten), .muteOut(mute), .shutdownOut(shut), .auxEnableOut(aux),
		.currentLimiterHoldTime(curlim), .interruptMaskGroup0(mask0), .irq(irq));

	// Clock and a sample pulse every fourth cycle
	always #5 clock = ~clock;
	always @(posedge clock) begin
		sc <= sc + 2'h1;
		strobe <= (sc == 2'h3);
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One classic cycle, held until ack or err is sampled; the watchdog ends a hang
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		do begin
			@(posedge clock);
		end while (ack !== 1'b1 && err !== 1'b1);
		rd = datOut;
		errSeen = err;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic waitc(input int n);
		repeat (n) @(posedge clock);
	endtask

	// Bounded wait for attenuation to become nonzero or zero
	task automatic waitAtt(input logic nz);
		int n;
		n = 0;
		while ((atten != 8'h00) !== nz && n < 6000) begin
			@(posedge clock);
			n++;
		end
		// A wait that runs out counts as a mismatch
		if (n >= 6000) fail_count++;
	endtask

	task automatic test_done;
		if (fail_count == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		waitc(60000);
		fail_count++;
		test_done;
	end

	// Main sequence
	initial begin
		waitc(16);
		reset <= 1'b0;
		foreach (ROWS[i]) begin
			if (ROWS[i][24]) begin
				wb(1'b1, ROWS[i][23:16], ROWS[i][15:8]);
			end
			wb(1'b0, ROWS[i][23:16], 8'h00);
			chk($sformatf("reg %h", ROWS[i][23:16]), {24'h0, ROWS[i][7:0]}, rd);
		end
		chk("aux enable", 1, aux);
		chk("curlim time", 7, curlim);
		chk("mask0", 8'h03, mask0);
		// A write without byte lane 0 is acknowledged and ignored
		sel <= 4'hE;
		wb(1'b1, 8'h19, 8'hFF);
		chk("lane 0 ack", 0, errSeen);
		sel <= 4'hF;
		wb(1'b0, 8'h19, 8'h00);
		chk("lane 0 off", 8'h5A, rd);
		wb(1'b0, 8'h30, 8'h00);
		chk("unmapped err", 1, errSeen);
		wb(1'b1, 8'h14, 8'h01);
		// Each attack step with a 10 ms hold
		for (int c = 0; c < 4; c++) begin
			wb(1'b1, 8'h20, 8'h0F);
			if (c == 3) begin
				wb(1'b1, 8'h21, 8'h00);
			end
			wb(1'b1, 8'h15, {3'h0, c[1:0], 3'h1});
			pin <= 1'b1;
			waitAtt(1'b1);
			chk("attack step", 2 * (c + 1), atten);
			pin <= 1'b0;
			waitc(10);
			held = atten;
			waitc(70);
			chk("hold", held, atten);
			waitAtt(1'b0);
			chk("released", 0, atten);
			chk("irq", c != 3, irq);
		end
		chk("no mute", 0, mute);
		wb(1'b1, 8'h21, 8'h0F);
		waitc(2);
		chk("irq unmasked", 1, irq);
		wb(1'b1, 8'h20, 8'h0F);
		waitc(2);
		chk("irq cleared", 0, irq);
		// Slowest rate, then infinite hold and release bit
		wb(1'b1, 8'h15, 8'hF8);
		wb(1'b1, 8'h14, 8'h05);
		pin <= 1'b1;
		waitAtt(1'b1);
		waitc(480);
		chk("rate hold", 8, atten);
		waitc(60);
		chk("rate step", 16, atten);
		pin <= 1'b0;
		waitc(300);
		chk("forever", 16, atten);
		// Slower, finer release: 2 qdB every 20 ms
		rlsStep <= 2'h1;
		rlsRate <= 3'h1;
		wb(1'b1, 8'h14, 8'h0D);
		waitc(150);
		chk("release rate", 16, atten);
		waitc(100);
		chk("release step", 14, atten);
		waitAtt(1'b0);
		chk("release bit", 0, atten);
		wb(1'b0, 8'h14, 8'h00);
		chk("self clear", 8'h05, rd);
		// Mute then shutdown, then reset in mid-run
		wb(1'b1, 8'h14, 8'h03);
		pin <= 1'b1;
		waitc(20);
		chk("mute", 1, mute);
		chk("shutdown", 1, shut);
		pin <= 1'b0;
		reset <= 1'b1;
		waitc(16);
		reset <= 1'b0;
		waitc(1);
		chk("mute reset", 0, mute);
		chk("shut reset", 0, shut);
		wb(1'b0, 8'h14, 8'h00);
		chk("control reset", 8'h01, rd);
		test_done;
	end
endmodule
